// ===== logic/dao_pkg.sv
// Shared constants, types and decode helpers for the dual converter output control.
// Assumes every user references items as dao_pkg::name.
package dao_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and depths
    localparam int DATA_W     = 12;
    localparam int WORD_W     = 13;
    localparam int PIPE_DEPTH = 5;
    localparam int FIFO_DEPTH = 8;
    localparam int PIN_COUNT  = 9;

    ////////////////////////////////////////////////////////////////////////////
    // Input pin vector field positions and the word's flag bit
    localparam int PIN_CLK_A   = 0;
    localparam int PIN_CLK_B   = 1;
    localparam int PIN_ROUTE   = 2;
    localparam int PIN_PD_A    = 3;
    localparam int PIN_PD_B    = 4;
    localparam int PIN_EN_N_A  = 5;
    localparam int PIN_EN_N_B  = 6;
    localparam int PIN_LEVEL_L = 7;
    localparam int PIN_LEVEL_H = 8;
    localparam int WORD_FLAG   = 12;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [11:0] RESET_CODE  = 12'h000;
    localparam logic        RESET_FLAG  = 1'h0;
    localparam logic        RESET_OE_N  = 1'h1;
    localparam logic [8:0]  RESET_PINS  = 9'h000;

    ////////////////////////////////////////////////////////////////////////////
    // Four-level format input, coded as a two-bit level
    localparam logic [1:0] LEVEL_GND   = 2'h0;
    localparam logic [1:0] LEVEL_THIRD = 2'h1;
    localparam logic [1:0] LEVEL_TWO3  = 2'h2;
    localparam logic [1:0] LEVEL_FULL  = 2'h3;

    typedef enum logic [1:0] {
        DAO_RUN_DRIVE = 2'b00,
        DAO_RUN_HIZ   = 2'b01,
        DAO_NAP       = 2'b10,
        DAO_SLEEP     = 2'b11
    } dao_pwr_t;

    localparam dao_pwr_t RESET_PWR = DAO_SLEEP;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic dao_pwr_t dao_pwr_decode(input logic pd, input logic en_n);
        dao_pwr_t m;
        m = DAO_SLEEP;
        unique case ({pd, en_n})
            2'b00: m = DAO_RUN_DRIVE;
            2'b01: m = DAO_RUN_HIZ;
            2'b10: m = DAO_NAP;
            2'b11: m = DAO_SLEEP;
        endcase
        return m;
    endfunction

    function automatic logic dao_is_twos(input logic [1:0] level);
        return (level == LEVEL_TWO3) || (level == LEVEL_FULL);
    endfunction

    function automatic logic dao_is_stab(input logic [1:0] level);
        return (level == LEVEL_THIRD) || (level == LEVEL_TWO3);
    endfunction

    function automatic logic [11:0] dao_format(input logic [11:0] code, input logic twos);
        return {code[11] ^ twos, code[10:0]};
    endfunction

endpackage

// ===== logic/dao_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module dao_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             do_wr;
    logic             do_rd;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign do_wr     = in_valid & in_ready;
    assign do_rd     = out_valid & out_ready;
    assign out_data  = mem[rd_ptr];

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointers and fill count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

endmodule // dao_fifo

// ===== logic/dao_top.sv
// Dual-channel converter output control: sampling pipeline, format, routing, power modes.
// Assumes the pin inputs are asynchronous and the conversion codes come from core_clk logic.
//
// Overview of operation
// (R1) Each channel samples on its own rising edge
// (R2) Route high: channel A on bus A
// (R3) Route low: channels swapped between buses
// (R4) Other party may tie route and clocks
// (R5) Shutdown low: convert; enable low drives outputs
// (R6) Shutdown high: nap or sleep, outputs high-Z
// (R7) Power and drive applied per channel
// (R8) One format input governs both channels
// (R9) Four levels decode format and stabilizer
// (R10) Twelve-bit result, top bit is MSB
// (R11) Range flag high on over or under
// (R12) Result appears five sample edges later
// (R13) Twos complement inverts MSB; flag travels along
// (R14) Nap and sleep stop all new results
`timescale 1ns/1ps
module dao_top (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        sample_clock_a,
    input  wire logic        sample_clock_b,
    input  wire logic        bus_route_select,
    input  wire logic        power_down_a,
    input  wire logic        power_down_b,
    input  wire logic        drive_enable_n_a,
    input  wire logic        drive_enable_n_b,
    input  wire logic [1:0]  format_mode_level,
    input  wire logic [11:0] conv_code_a,
    input  wire logic        conv_range_a,
    input  wire logic [11:0] conv_code_b,
    input  wire logic        conv_range_b,
    output logic      [11:0] result_bus_a,
    output logic             range_flag_a,
    output logic             result_oe_n_a,
    output logic      [11:0] result_bus_b,
    output logic             range_flag_b,
    output logic             result_oe_n_b,
    output logic             stabilizer_on,
    output logic             twos_complement_on,
    output logic             sample_lost_a,
    output logic             sample_lost_b
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [dao_pkg::PIN_COUNT-1:0] pin_raw;
    logic [dao_pkg::PIN_COUNT-1:0] pin_meta;
    logic [dao_pkg::PIN_COUNT-1:0] pin_sync;
    logic [1:0]                    clk_s;
    logic [1:0]                    pd_s;
    logic [1:0]                    en_n_s;
    logic                          route_s;
    logic [1:0]                    level_s;
    logic [11:0]                   code_in [2];
    logic [1:0]                    range_in;
    logic [1:0]                    level_prev;

    assign pin_raw = {format_mode_level, drive_enable_n_b, drive_enable_n_a,
                      power_down_b, power_down_a, bus_route_select, sample_clock_b, sample_clock_a};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_meta <= dao_pkg::RESET_PINS;
            pin_sync <= dao_pkg::RESET_PINS;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    assign clk_s   = {pin_sync[dao_pkg::PIN_CLK_B], pin_sync[dao_pkg::PIN_CLK_A]};
    assign pd_s    = {pin_sync[dao_pkg::PIN_PD_B], pin_sync[dao_pkg::PIN_PD_A]};
    assign en_n_s  = {pin_sync[dao_pkg::PIN_EN_N_B], pin_sync[dao_pkg::PIN_EN_N_A]};
    assign route_s = pin_sync[dao_pkg::PIN_ROUTE];
    assign level_s = pin_sync[dao_pkg::PIN_LEVEL_H:dao_pkg::PIN_LEVEL_L];

    assign code_in[0] = conv_code_a;
    assign code_in[1] = conv_code_b;
    assign range_in   = {conv_range_b, conv_range_a};

    ////////////////////////////////////////////////////////////////////////////
    // Shared format and stabilizer
    // (R8) (R9) Shared level decode
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level_prev         <= dao_pkg::LEVEL_GND;
            twos_complement_on <= 1'h0;
            stabilizer_on      <= 1'h0;
        end else begin
            level_prev <= level_s;
            // Level bits may settle a cycle apart; act on agreement
            if (level_s == level_prev) begin
                twos_complement_on <= dao_pkg::dao_is_twos(level_s);
                stabilizer_on      <= dao_pkg::dao_is_stab(level_s);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel pipeline, buffer and result register
    for (genvar ch = 0; ch < 2; ch++) begin : chan
        dao_pkg::dao_pwr_t            pwr;
        logic                         prev_clk;
        logic                         edge_hit;
        logic                         active;
        logic                         advance;
        logic                         push;
        logic                         in_ready;
        logic                         out_valid;
        logic                         pop;
        logic [dao_pkg::WORD_W-1:0]   fifo_q;
        logic [dao_pkg::PIPE_DEPTH-1:0] st_vld;
        logic [dao_pkg::WORD_W-1:0]   st [dao_pkg::PIPE_DEPTH];
        logic [11:0]                  word;
        logic                         flag;
        logic                         hiz;
        logic                         lost;

        // (R1) Own clock edge
        assign edge_hit = clk_s[ch] & ~prev_clk;
        assign active   = (pwr == dao_pkg::DAO_RUN_DRIVE) || (pwr == dao_pkg::DAO_RUN_HIZ);
        // (R14) Halted when asleep
        assign advance  = edge_hit & active & in_ready;
        assign push     = advance & st_vld[dao_pkg::PIPE_DEPTH-1];
        assign pop      = out_valid & active;
        // (R5) (R6) Drive only in normal mode
        assign hiz      = (pwr != dao_pkg::DAO_RUN_DRIVE);

        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                prev_clk <= 1'h0;
            end else begin
                prev_clk <= clk_s[ch];
            end
        end

        // (R7) Per-channel power state
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                pwr <= dao_pkg::RESET_PWR;
            end else begin
                pwr <= dao_pkg::dao_pwr_decode(pd_s[ch], en_n_s[ch]);
            end
        end

        // (R12) Five-stage sample pipeline
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                st_vld <= '0;
            end else if (!active) begin
                st_vld <= '0;
            end else if (advance) begin
                st_vld <= {st_vld[dao_pkg::PIPE_DEPTH-2:0], 1'h1};
            end
        end

        // (R11) Flag rides with its code
        always_ff @(posedge core_clk) begin
            if (advance) begin
                st[0] <= {range_in[ch], code_in[ch]};
                for (int i = 1; i < dao_pkg::PIPE_DEPTH; i++) begin
                    st[i] <= st[i-1];
                end
            end
        end

        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                lost <= 1'h0;
            end else begin
                lost <= edge_hit & active & ~in_ready;
            end
        end

        dao_fifo #(
            .WIDTH (dao_pkg::WORD_W),
            .DEPTH (dao_pkg::FIFO_DEPTH)
        ) u_fifo (
            .core_clk  (core_clk),
            .rst       (rst),
            .in_valid  (push),
            .in_ready  (in_ready),
            .in_data   (st[dao_pkg::PIPE_DEPTH-1]),
            .out_valid (out_valid),
            .out_ready (active),
            .out_data  (fifo_q)
        );

        // (R13) Format applied on release
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                word <= dao_pkg::RESET_CODE;
                flag <= dao_pkg::RESET_FLAG;
            end else if (pop) begin
                word <= dao_pkg::dao_format(fifo_q[11:0], twos_complement_on);
                flag <= fifo_q[dao_pkg::WORD_FLAG];
            end
        end
    end

    assign sample_lost_a = chan[0].lost;
    assign sample_lost_b = chan[1].lost;

    ////////////////////////////////////////////////////////////////////////////
    // Bus routing
    // (R2) (R3) (R10) Route or swap buses
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            result_bus_a  <= dao_pkg::RESET_CODE;
            range_flag_a  <= dao_pkg::RESET_FLAG;
            result_oe_n_a <= dao_pkg::RESET_OE_N;
            result_bus_b  <= dao_pkg::RESET_CODE;
            range_flag_b  <= dao_pkg::RESET_FLAG;
            result_oe_n_b <= dao_pkg::RESET_OE_N;
        end else if (route_s) begin
            result_bus_a  <= chan[0].word;
            range_flag_a  <= chan[0].flag;
            result_oe_n_a <= chan[0].hiz;
            result_bus_b  <= chan[1].word;
            range_flag_b  <= chan[1].flag;
            result_oe_n_b <= chan[1].hiz;
        end else begin
            result_bus_a  <= chan[1].word;
            range_flag_a  <= chan[1].flag;
            result_oe_n_a <= chan[1].hiz;
            result_bus_b  <= chan[0].word;
            range_flag_b  <= chan[0].flag;
            result_oe_n_b <= chan[0].hiz;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    route_direct_a: assert property ( // (R2)
        route_s |=> (result_bus_a == $past(chan[0].word)) && (range_flag_b == $past(chan[1].flag)))
        else $error("direct routing wrong");

    route_swap_a: assert property ( // (R3)
        !route_s |=> (result_bus_b == $past(chan[0].word)) && (range_flag_a == $past(chan[1].flag)))
        else $error("swapped routing wrong");

    normal_drive_a: assert property ( // (R5)
        (!pd_s[0] && !en_n_s[0] && route_s) ##1 route_s |=> !result_oe_n_a)
        else $error("normal channel not driven");

    nap_mode_a: assert property ( // (R6)
        (pd_s[0] && !en_n_s[0]) |=> (chan[0].pwr == dao_pkg::DAO_NAP) ##1 (!$past(route_s) || result_oe_n_a))
        else $error("nap entry wrong");

    sleep_mode_a: assert property ( // (R7)
        (pd_s[1] && en_n_s[1] && !pd_s[0] && !en_n_s[0]) |=>
            (chan[1].pwr == dao_pkg::DAO_SLEEP) && (chan[0].pwr == dao_pkg::DAO_RUN_DRIVE))
        else $error("per-channel power wrong");

    level_decode_a: assert property ( // (R9)
        (level_s == dao_pkg::LEVEL_THIRD) && (level_prev == dao_pkg::LEVEL_THIRD) |=>
            stabilizer_on && !twos_complement_on)
        else $error("level decode wrong");

    full_level_a: assert property ( // (R9)
        (level_s == dao_pkg::LEVEL_FULL) && (level_prev == dao_pkg::LEVEL_FULL) |=>
            !stabilizer_on && twos_complement_on)
        else $error("full level decode wrong");

    edge_only_a: assert property ( // (R1)
        !(clk_s[0] && !chan[0].prev_clk) |=> $stable(chan[0].st_vld) || (chan[0].st_vld == '0))
        else $error("pipeline moved without edge");

    five_deep_a: assert property ( // (R12)
        chan[0].push |-> chan[0].edge_hit && (chan[0].st_vld == 5'h1F))
        else $error("result leaves before five edges");

    msb_invert_a: assert property ( // (R13)
        (chan[0].pop && twos_complement_on) |=>
            (chan[0].word[11] == ~$past(chan[0].fifo_q[11])) && (chan[0].flag == $past(chan[0].fifo_q[12])))
        else $error("twos complement format wrong");

    range_flag_a_a: assert property ( // (R11)
        (chan[0].pop && chan[0].fifo_q[12]) |=> chan[0].flag)
        else $error("range flag lost");

    stop_asleep_a: assert property ( // (R14)
        !chan[0].active |-> !chan[0].push && !chan[0].pop)
        else $error("results while asleep");

    asleep_hold_a: assert property ( // (R14)
        !chan[1].active |=> $stable(chan[1].word) && $stable(chan[1].flag))
        else $error("channel word moved while asleep");

    route_enable_a: assert property ( // (R2)
        route_s |=> (result_oe_n_b == $past(chan[1].hiz)) && (result_oe_n_a == $past(chan[0].hiz)))
        else $error("output enable not routed");

    cover_result_a: cover property (chan[0].pop ##1 route_s ##1 !result_oe_n_a);
    cover_swap_a: cover property (!route_s && chan[0].pop);
    cover_nap_a: cover property (chan[0].pwr == dao_pkg::DAO_NAP);
    cover_full_a: cover property (!chan[1].in_ready);
    cover_sleep_a: cover property (chan[1].pwr == dao_pkg::DAO_SLEEP);

endmodule // dao_top

// ===== verif/dao_bus_receiver.sv
// Receiving logic that captures the parallel result words off one output bus.
// Assumes the bus and its output enable come from registers on core_clk.
`timescale 1ns/1ps
module dao_bus_receiver (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        oe_n,
    input  wire logic [11:0] bus,
    input  wire logic        flag,
    output logic      [12:0] seen_word
);
    logic [12:0] last_word;

    ////////////////////////////////////////////////////////////////////////////
    // flag above MSB-first word
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            last_word <= 13'h0000;
        end else if (!oe_n) begin
            last_word <= {flag, bus};
        end
    end

    // Released bus shows inverse of last value
    assign seen_word = oe_n ? ~last_word : {flag, bus};
endmodule // dao_bus_receiver

// ===== verif/dual_adc_output_control_bench.sv
// Self-checking bench for the dual converter output control.
// Assumes dao_pkg, dao_fifo and dao_top are compiled first.
`timescale 1ns/1ps
module dual_adc_output_control_bench;
    logic        core_clk, rst, sample_clock_a, sample_clock_b, bus_route_select;
    logic        power_down_a, power_down_b, drive_enable_n_a, drive_enable_n_b;
    logic [1:0]  format_mode_level;
    logic [11:0] conv_code_a, conv_code_b, result_bus_a, result_bus_b;
    logic        conv_range_a, conv_range_b, range_flag_a, range_flag_b;
    logic        result_oe_n_a, result_oe_n_b, stabilizer_on, twos_complement_on;
    logic        sample_lost_a, sample_lost_b;
    logic [12:0] seen_a, seen_b, cur_a, cur_b;
    logic [31:0] seed;
    logic [12:0] qa[$], qb[$];
    int          n_errors, check_count;

    dao_top u_dao_top (.core_clk(core_clk), .rst(rst), .sample_clock_a(sample_clock_a),
        .sample_clock_b(sample_clock_b), .bus_route_select(bus_route_select),
        .power_down_a(power_down_a), .power_down_b(power_down_b), .drive_enable_n_a(drive_enable_n_a),
        .drive_enable_n_b(drive_enable_n_b), .format_mode_level(format_mode_level),
        .conv_code_a(conv_code_a), .conv_range_a(conv_range_a), .conv_code_b(conv_code_b),
        .conv_range_b(conv_range_b), .result_bus_a(result_bus_a), .range_flag_a(range_flag_a),
        .result_oe_n_a(result_oe_n_a), .result_bus_b(result_bus_b), .range_flag_b(range_flag_b),
        .result_oe_n_b(result_oe_n_b), .stabilizer_on(stabilizer_on),
        .twos_complement_on(twos_complement_on), .sample_lost_a(sample_lost_a),
        .sample_lost_b(sample_lost_b));
    dao_bus_receiver u_rx_a (.core_clk(core_clk), .rst(rst), .oe_n(result_oe_n_a), .bus(result_bus_a),
        .flag(range_flag_a), .seen_word(seen_a));
    dao_bus_receiver u_rx_b (.core_clk(core_clk), .rst(rst), .oe_n(result_oe_n_b), .bus(result_bus_b),
        .flag(range_flag_b), .seen_word(seen_b));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, verdict and helpers
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic test_done();
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Model output word: MSB flipped for twos complement
    function automatic logic [12:0] fmt(input logic [12:0] w);
        return {w[12], w[11] ^ format_mode_level[1], w[10:0]};
    endfunction

    // n sample periods, clock mask m selects the toggling channels
    task automatic run_sample(input int n, input logic [1:0] m);
        logic [31:0] r;
        repeat (n) begin
            r = rnd();
            @(negedge core_clk);
            conv_code_a = r[11:0];
            conv_range_a = r[12];
            conv_code_b = r[27:16];
            conv_range_b = r[28];
            sample_clock_a = m[0];
            sample_clock_b = m[1];
            // each channel on its own edge
            if (m[0] && !power_down_a) begin
                qa.push_back({r[12], r[11:0]});
                if (qa.size() > 5) cur_a = qa.pop_front();
            end
            if (m[1] && !power_down_b) begin
                qb.push_back({r[28], r[27:16]});
                if (qb.size() > 5) cur_b = qb.pop_front();
            end
            repeat (4) @(negedge core_clk);
            sample_clock_a = 1'b0;
            sample_clock_b = 1'b0;
            repeat (4) @(negedge core_clk);
        end
    endtask

    // Compare both buses with the model
    task automatic check_all();
        logic da, db, oa, ob;
        da = !power_down_a && !drive_enable_n_a;
        db = !power_down_b && !drive_enable_n_b;
        oa = bus_route_select ? da : db;
        ob = bus_route_select ? db : da;
        check({12'h000, result_oe_n_a}, {12'h000, !oa});
        check({12'h000, result_oe_n_b}, {12'h000, !ob});
        if (oa) check(seen_a, fmt(bus_route_select ? cur_a : cur_b));
        if (ob) check(seen_b, fmt(bus_route_select ? cur_b : cur_a));
        check({11'h000, sample_lost_a, sample_lost_b}, 13'h0000);
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        $display("CHECK FAILED t=%0t run did not finish", $time);
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [12:0] held;
        n_errors = 0;
        check_count = 0;
        seed = 32'hC6223349;
        rst = 1'b1;
        {sample_clock_a, sample_clock_b, bus_route_select, power_down_a, power_down_b} = 5'h00;
        {drive_enable_n_a, drive_enable_n_b, conv_range_a, conv_range_b} = 4'h0;
        format_mode_level = 2'h0;
        conv_code_a = 12'h000;
        conv_code_b = 12'h000;
        cur_a = 13'h0000;
        cur_b = 13'h0000;
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        for (int lev = 0; lev < 4; lev++) begin
            for (int rt = 0; rt < 2; rt++) begin
                format_mode_level = lev[1:0];
                bus_route_select = rt[0];
                run_sample(7, 2'b11);
                check({12'h000, stabilizer_on}, {12'h000, lev == 1 || lev == 2});
                check({12'h000, twos_complement_on}, {12'h000, lev >= 2});
                check_all();
            end
        end
        run_sample(3, 2'b10);
        check_all();
        // channel A high impedance while converting
        drive_enable_n_a = 1'b1;
        run_sample(2, 2'b11);
        check_all();
        // nap then sleep on channel A
        for (int s = 0; s < 2; s++) begin
            bus_route_select = s[0];
            drive_enable_n_a = s[0];
            power_down_a = 1'b1;
            repeat (6) @(negedge core_clk);
            qa.delete();
            held = bus_route_select ? {range_flag_a, result_bus_a} : {range_flag_b, result_bus_b};
            run_sample(6, 2'b11);
            check_all();
            check(bus_route_select ? {range_flag_a, result_bus_a} : {range_flag_b, result_bus_b}, held);
        end
        power_down_a = 1'b0;
        drive_enable_n_a = 1'b0;
        repeat (4) @(negedge core_clk);
        run_sample(6, 2'b11);
        check_all();
        // channel B down, channel A unaffected
        power_down_b = 1'b1;
        repeat (6) @(negedge core_clk);
        qb.delete();
        run_sample(3, 2'b11);
        check_all();
        test_done();
    end
endmodule // dual_adc_output_control_bench
